/* core/cpu_status_flag_register.sv */
/*
 Processor status register: arithmetic flags, watchdog and sleep
 status, bank selects, and arbitration of instruction writes against
 hardware flag updates. Assumes the execution unit presents one
 operation per clock with its destination address and write strobe.
*/
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Flag-updating ops writing status keep computed flags, not written data.
// - Instruction writes never change watchdog_expired_n or sleep_entered_n.
// - Clear on status zeroes bank bits, sets zero flag, keeps others.
// - Bit set/clear, swap and store ops leave flags to the write.
// - indirect_bank_hi picks banks 2-3 when 1, banks 0-1 when 0.
// - Direct bank bits pick one of four 128-byte banks.
// - Watchdog bit set by power-up, watchdog clear, sleep; cleared on timeout.
// - Sleep bit set by power-up or watchdog clear; cleared by sleep.
// - Zero flag follows whether the result is zero.
// - Nibble flag is carry from bit 3, inverted borrow on subtract.
// - Carry flag is carry out of msb, inverted borrow on subtract.
// - Subtraction adds the two's complement of the second operand.
// - Rotates go through carry, loading low or high source bit.
// - Status register is seen at addresses 03h, 83h, 103h and 183h.
module cpu_status_flag_register
	import status_pkg::*;
(
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     arst_n,
	// Operation from execution unit
	input  wire status_pkg::op_class_e    op,
	input  wire logic [status_pkg::DATA_W-1:0] opnd_a,
	input  wire logic [status_pkg::DATA_W-1:0] opnd_b,
	input  wire logic                     dest_wr,
	input  wire logic [status_pkg::ADDR_W-1:0] dest_addr,
	input  wire logic [status_pkg::DATA_W-1:0] store_data,
	// Hardware events
	input  wire logic                     watchdog_timeout,
	// Addressing requests
	input  wire logic [6:0]               direct_offset,
	input  wire logic [status_pkg::DATA_W-1:0] indirect_ptr,
	// Outputs
	output logic [status_pkg::DATA_W-1:0] cpu_status,
	output logic [status_pkg::ADDR_W-1:0] direct_addr,
	output logic [status_pkg::ADDR_W-1:0] indirect_addr,
	output logic [status_pkg::DATA_W-1:0] alu_result
);
	import status_pkg::*;

	function automatic logic is_status(input logic [ADDR_W-1:0] a);
		// Mirrored in every bank, low seven bits decide
		return a[6:0] == STATUS_ADDR_LO;
	endfunction

	function automatic logic sets_flags(input op_class_e o);
		return o inside {OP_ADD, OP_SUB, OP_LOGIC, OP_CLEAR,
			OP_ROT_RIGHT, OP_ROT_LEFT};
	endfunction

	logic [DATA_W-1:0] status_reg, status_next;
	logic [ADDR_W-1:0] daddr_reg, daddr_next;
	logic [ADDR_W-1:0] iaddr_reg, iaddr_next;
	logic [DATA_W-1:0] res_reg, res_next;
	logic [DATA_W-1:0] res_c;
	logic              z_c, dc_c, c_c, wr_status;

	status_alu u_alu (
		.op        (op),
		.opnd_a    (opnd_a),
		.opnd_b    (opnd_b),
		.carry_in  (status_reg[BIT_CARRY]),
		.result    (res_c),
		.zero      (z_c),
		.nibble_cy (dc_c),
		.carry_out (c_c)
	);

	always_comb begin
		status_next = status_reg;
		wr_status = dest_wr && is_status(dest_addr);
		res_next = (op == OP_MOVE) ? store_data : res_c;
		if (wr_status) begin
			// Writable bits take the result; flags masked below
			status_next[BIT_IND_HI] = res_next[BIT_IND_HI];
			status_next[BIT_BANK_HI] = res_next[BIT_BANK_HI];
			status_next[BIT_BANK_LO] = res_next[BIT_BANK_LO];
			if (!sets_flags(op)) begin
				status_next[BIT_ZERO] = res_next[BIT_ZERO];
				status_next[BIT_NIBBLE] = res_next[BIT_NIBBLE];
				status_next[BIT_CARRY] = res_next[BIT_CARRY];
			end
		end
		// Hardware flag updates win over the written value
		if (sets_flags(op)) begin
			status_next[BIT_ZERO] = z_c;
			if (op == OP_ADD || op == OP_SUB) begin
				status_next[BIT_NIBBLE] = dc_c;
				status_next[BIT_CARRY] = c_c;
			end
			if (op == OP_ROT_RIGHT || op == OP_ROT_LEFT)
				status_next[BIT_CARRY] = c_c;
			if (op == OP_CLEAR && wr_status)
				status_next = (status_reg & CLEAR_MASK)
					| (8'h01 << BIT_ZERO);
		end
		// Status bits: only events, never writes
		if (op == OP_WDOG_CLEAR) begin
			status_next[BIT_WDOG] = 1'b1;
			status_next[BIT_SLEEP] = 1'b1;
		end else if (op == OP_SLEEP) begin
			status_next[BIT_WDOG] = 1'b1;
			status_next[BIT_SLEEP] = 1'b0;
		end else begin
			status_next[BIT_WDOG] = status_reg[BIT_WDOG];
			status_next[BIT_SLEEP] = status_reg[BIT_SLEEP];
		end
		if (watchdog_timeout)
			status_next[BIT_WDOG] = 1'b0;
		// Bank selection on next-state so it follows the latest write
		daddr_next = {status_next[BIT_BANK_HI], status_next[BIT_BANK_LO],
			direct_offset};
		iaddr_next = {status_next[BIT_IND_HI], indirect_ptr};
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			status_reg <= STATUS_RESET;
			daddr_reg <= '0;
			iaddr_reg <= '0;
			res_reg <= '0;
		end else begin
			status_reg <= status_next;
			daddr_reg <= daddr_next;
			iaddr_reg <= iaddr_next;
			res_reg <= res_next;
		end
	end

	assign cpu_status = status_reg;
	assign direct_addr = daddr_reg;
	assign indirect_addr = iaddr_reg;
	assign alu_result = res_reg;

	a_write_no_status: assert property (@(posedge clk) disable iff (!arst_n)
		(op == OP_MOVE && !watchdog_timeout) |=>
		cpu_status[4:3] == $past(cpu_status[4:3]))
		else $error("status bits changed by write");
	a_clear_status: assert property (@(posedge clk) disable iff (!arst_n)
		(op == OP_CLEAR && dest_wr && dest_addr[6:0] == 7'h03
		&& !watchdog_timeout) |=> cpu_status[7:5] == 3'h0
		&& cpu_status[2] && cpu_status[1:0] == $past(cpu_status[1:0]))
		else $error("clear of status wrong");
	a_flags_win: assert property (@(posedge clk) disable iff (!arst_n)
		(op == OP_ADD) |=> cpu_status[2] == (alu_result == 8'h00))
		else $error("zero flag mismatch");
	a_move_flags: assert property (@(posedge clk) disable iff (!arst_n)
		(op == OP_MOVE && dest_wr && dest_addr[6:0] == 7'h03) |=>
		cpu_status[2:0] == $past(store_data[2:0]))
		else $error("move did not store flags");
	a_indirect_bank: assert property (@(posedge clk) disable iff (!arst_n)
		indirect_addr[8] == cpu_status[7])
		else $error("indirect bank mismatch");
	a_direct_bank: assert property (@(posedge clk) disable iff (!arst_n)
		direct_addr[8:7] == cpu_status[6:5])
		else $error("direct bank mismatch");
	a_wdog_timeout: assert property (@(posedge clk) disable iff (!arst_n)
		watchdog_timeout |=> !cpu_status[4])
		else $error("timeout not recorded");
	a_sleep_entry: assert property (@(posedge clk) disable iff (!arst_n)
		(op == OP_SLEEP) |=> !cpu_status[3])
		else $error("sleep not recorded");
	a_sub_borrow: assert property (@(posedge clk) disable iff (!arst_n)
		(op == OP_SUB) |=> cpu_status[0] == ($past(opnd_a) >= $past(opnd_b)))
		else $error("subtract carry wrong");
	a_rotate_left: assert property (@(posedge clk) disable iff (!arst_n)
		(op == OP_ROT_LEFT) |=> cpu_status[0] == $past(opnd_a[7])
		&& alu_result[0] == $past(cpu_status[0]))
		else $error("rotate left wrong");
endmodule // cpu_status_flag_register
`default_nettype wire

/* include/status_pkg.sv */
/*
 Constants for the processor status flag register: bit positions,
 reset values, addresses and the operation classes it reacts to.
 Assumes an 8-bit data path and a 9-bit data-memory address.
*/
package status_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 9;
	localparam int BIT_CARRY = 0;
	localparam int BIT_NIBBLE = 1;
	localparam int BIT_ZERO = 2;
	localparam int BIT_SLEEP = 3;
	localparam int BIT_WDOG = 4;
	localparam int BIT_BANK_LO = 5;
	localparam int BIT_BANK_HI = 6;
	localparam int BIT_IND_HI = 7;
	localparam logic [6:0] STATUS_ADDR_LO = 7'h03;
	localparam logic [7:0] STATUS_ADDR_B0 = 8'h03;
	localparam logic [7:0] STATUS_ADDR_B1 = 8'h83;
	localparam logic [7:0] STATUS_RESET = 8'h18;
	localparam logic [7:0] CLEAR_MASK = 8'h1F;
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_ADD = 4'h1,
		OP_SUB = 4'h2,
		OP_LOGIC = 4'h3,
		OP_CLEAR = 4'h4,
		OP_ROT_RIGHT = 4'h5,
		OP_ROT_LEFT = 4'h6,
		OP_MOVE = 4'h7,
		OP_WDOG_CLEAR = 4'h8,
		OP_SLEEP = 4'h9
	} op_class_e;
endpackage

/* core/status_alu.sv */
/*
 Flag-producing arithmetic for the status register: add, subtract by
 two's complement, rotate through carry, logic result zero test.
 Assumes operands valid in the same cycle as the operation class.
*/
`timescale 1ns/100ps
`default_nettype none
module status_alu
	import status_pkg::*;
(
	// Operation
	input  wire op_class_e            op,
	input  wire logic [DATA_W-1:0]    opnd_a,
	input  wire logic [DATA_W-1:0]    opnd_b,
	input  wire logic                 carry_in,
	// Results
	output logic      [DATA_W-1:0]    result,
	output logic                      zero,
	output logic                      nibble_cy,
	output logic                      carry_out
);
	logic [DATA_W:0] sum;
	logic [4:0]      low_sum;
	logic [DATA_W-1:0] b_eff;
	logic            sub_in;

	always_comb begin
		sub_in = (op == OP_SUB);
		// Subtract adds complement plus one; carries become not-borrow
		b_eff = sub_in ? ~opnd_b : opnd_b;
		sum = {1'b0, opnd_a} + {1'b0, b_eff} + {{DATA_W{1'b0}}, sub_in};
		low_sum = {1'b0, opnd_a[3:0]} + {1'b0, b_eff[3:0]}
			+ {4'h0, sub_in};
		result = sum[DATA_W-1:0];
		nibble_cy = low_sum[4];
		carry_out = sum[DATA_W];
		unique case (op)
			OP_ROT_RIGHT: begin
				result = {carry_in, opnd_a[DATA_W-1:1]};
				carry_out = opnd_a[0];
			end
			OP_ROT_LEFT: begin
				result = {opnd_a[DATA_W-2:0], carry_in};
				carry_out = opnd_a[DATA_W-1];
			end
			OP_LOGIC: result = opnd_a;
			OP_CLEAR: result = '0;
			default: ;
		endcase
		zero = (result == '0);
	end
endmodule // status_alu
`default_nettype wire

/* tb/exec_unit_model.sv */
/*
 Execution unit model: presents one operation per clock to the status
 register. Assumes the bench calls issue once per cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module exec_unit_model
	import status_pkg::*;
#(
	parameter bit HAS_HI_BANKS = 1'b1
)(
	// Clock
	input  wire logic                         clk,
	// Operation to the status register
	output status_pkg::op_class_e             op,
	output logic [status_pkg::DATA_W-1:0]     opnd_a,
	output logic [status_pkg::DATA_W-1:0]     opnd_b,
	output logic                              dest_wr,
	output logic [status_pkg::ADDR_W-1:0]     dest_addr,
	output logic [status_pkg::DATA_W-1:0]     store_data,
	output logic                              watchdog_timeout,
	// Addressing requests
	output logic [6:0]                        direct_offset,
	output logic [status_pkg::DATA_W-1:0]     indirect_ptr
);
	assign direct_offset = opnd_a[6:0];
	assign indirect_ptr = opnd_b;
	initial begin
		op = OP_NONE;
		{opnd_a, opnd_b, dest_wr, dest_addr, store_data} = '0;
		watchdog_timeout = 1'b0;
	end
	// Drive at the falling edge, return just after the taking edge
	task automatic issue(input op_class_e o, input logic [7:0] a, b,
			input logic [9:0] wa, input logic [7:0] d, input logic t);
		@(negedge clk);
		if (!HAS_HI_BANKS && wa[6:0] == 7'h03) d[7:6] = 2'b00;
		op = o;
		{opnd_a, opnd_b, dest_wr, dest_addr, store_data} = {a, b, wa, d};
		watchdog_timeout = t;
		@(posedge clk);
		#1;
	endtask
endmodule // exec_unit_model
`default_nettype wire

/* tb/cpu_status_flag_register_bench.sv */
/*
 Self-checking bench for the status flag register.
 Assumes the execution model drives all design inputs except clk and arst_n.
*/
`timescale 1ns/100ps
`default_nettype none
module cpu_status_flag_register_bench;
	import status_pkg::*;
	logic       clk = 1'b0;
	logic       arst_n = 1'b0;
	op_class_e  op;
	logic [7:0] opnd_a, opnd_b, store_data, cpu_status, alu_result;
	logic [7:0] indirect_ptr, exp_st;
	logic [6:0] direct_offset;
	logic [8:0] dest_addr, direct_addr, indirect_addr;
	logic       dest_wr, watchdog_timeout;
	logic [10:0] r;
	int         miscompares = 0;
	int         cmp_count = 0;
	always #2.5 clk = ~clk;
	exec_unit_model i_exec (.clk(clk), .op(op), .opnd_a(opnd_a),
		.opnd_b(opnd_b), .dest_wr(dest_wr), .dest_addr(dest_addr),
		.store_data(store_data), .watchdog_timeout(watchdog_timeout),
		.direct_offset(direct_offset), .indirect_ptr(indirect_ptr));
	cpu_status_flag_register i_dut (.clk(clk), .arst_n(arst_n), .op(op),
		.opnd_a(opnd_a), .opnd_b(opnd_b), .dest_wr(dest_wr),
		.dest_addr(dest_addr), .store_data(store_data),
		.watchdog_timeout(watchdog_timeout), .direct_offset(direct_offset),
		.indirect_ptr(indirect_ptr), .cpu_status(cpu_status),
		.direct_addr(direct_addr), .indirect_addr(indirect_addr),
		.alu_result(alu_result));
	task automatic check(input logic [8:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One operation, then the whole status byte against its expectation
	task automatic step(input op_class_e o, input logic [7:0] a, b,
			input logic [9:0] wa, input logic [7:0] d, t, e);
		i_exec.issue(o, a, b, wa, d, t[0]);
		exp_st = e;
		check({1'b0, cpu_status}, {1'b0, e});
	endtask
	// Result, zero, nibble carry, carry; subtract adds two's complement
	function automatic logic [10:0] arith(logic s, logic [7:0] a, b);
		logic [7:0] m;
		logic [8:0] w;
		logic [4:0] n;
		m = s ? ~b : b;
		w = {1'b0, a} + {1'b0, m} + {8'h00, s};
		n = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, s};
		return {w[7:0], w[7:0] == 8'h00, n[4], w[8]};
	endfunction
	task automatic report_and_stop;
		$display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk);
		check({4'h0, cpu_status[7:3]}, 9'h003);
		arst_n = 1'b1;
		step(OP_MOVE, 0, 0, 10'h203, 8'hFF, 0, 8'hFF);
		step(OP_MOVE, 0, 0, 10'h283, 8'h00, 0, 8'h18);
		for (int i = 0; i < 4; i++) begin
			step(OP_MOVE, 0, 0, 10'h203, {i[0], i[1:0], 5'h0}, 0,
				{i[0], i[1:0], 5'h18});
			i_exec.issue(OP_NONE, 8'h7F, 8'hA5, 10'h000, 8'h00, 1'b0);
			check(direct_addr, {i[1:0], 7'h7F});
			check(indirect_addr, {i[0], 8'hA5});
		end
		for (int i = 0; i < 4; i++) begin
			r = arith(i[1], i[0] ? 8'hFF : 8'h05 - 8'h02 * i[1],
				8'h01 + 8'h02 * i[1]);
			step(op_class_e'(i[1] ? OP_SUB : OP_ADD),
				i[0] ? 8'hFF : 8'h05 - 8'h02 * i[1],
				8'h01 + 8'h02 * i[1], 10'h203, 8'h00, 0,
				{r[10:8], exp_st[4:3], r[2:0]});
			check({1'b0, alu_result}, {1'b0, r[10:3]});
		end
		step(OP_LOGIC, 0, 0, 10'h000, 0, 0, exp_st | 8'h04);
		// Carry in is 1, left by the last subtract; nibble flag untouched
		step(OP_ROT_LEFT, 8'h81, 0, 10'h000, 0, 0,
			{exp_st[7:3], 1'b0, exp_st[1], 1'b1});
		check({1'b0, alu_result}, 9'h003);
		step(OP_ROT_RIGHT, 8'h00, 0, 10'h000, 0, 0,
			{exp_st[7:3], 1'b0, exp_st[1], 1'b0});
		check({1'b0, alu_result}, 9'h080);
		step(OP_CLEAR, 0, 0, 10'h283, 0, 0,
			{3'b000, exp_st[4:3], 1'b1, exp_st[1:0]});
		step(OP_MOVE, 0, 0, 10'h000, 0, 1, exp_st & 8'hEF);
		step(OP_WDOG_CLEAR, 0, 0, 10'h000, 0, 0, exp_st | 8'h18);
		step(OP_SLEEP, 0, 0, 10'h000, 0, 0, exp_st & 8'hF7);
		step(OP_MOVE, 0, 0, 10'h203, 8'hFF, 0, 8'hF7);
		step(OP_SLEEP, 0, 0, 10'h000, 0, 1, 8'hE7);
		step(OP_NONE, 0, 0, 10'h000, 0, 0, 8'hE7);
		@(negedge clk);
		arst_n = 1'b0;
		#1;
		check({4'h0, cpu_status[7:3]}, 9'h003);
		@(negedge clk);
		arst_n = 1'b1;
		step(OP_NONE, 0, 0, 10'h000, 0, 0, 8'h18);
		check(direct_addr, 9'h000);
		report_and_stop();
	end
endmodule // cpu_status_flag_register_bench
`default_nettype wire
